// >>> flash_block_protection.sv
// flash array with block erase and read-only / execute-only protection units
//
// How it works
// R1: 256 KB flash array behind the controller
// R2: 1 KB erase blocks, erased independently
// R3: erased block reads back all ones
// R4: block pairs form 2 KB protection units
// R5: read-only unit refuses erase and program
// R6: execute-only unit refuses erase and program
// R7: execute-only unit serves instruction fetch only
// R8: execute-only unit denies debugger reads
// R9: permitted reads answer with no wait states
// R10: refused access sets sticky violation flag
`include "flash_block_protection_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module flash_block_protection
  import flash_block_protection_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid, // access request strobe
  input wire access_kind_t req_kind, // kind of access
  input wire logic [`FBP_ADDR_W-1:0] req_addr, // word address
  input wire logic [`FBP_DATA_W-1:0] req_wdata, // program data
  input wire logic prot_set, // attribute set strobe
  input wire logic [`FBP_UNIT_W-1:0] prot_set_unit, // unit being marked
  input wire logic prot_set_ro, // mark read-only
  input wire logic prot_set_xo, // mark execute-only
  input wire logic viol_clear, // clears the violation flag
  output logic rsp_valid, // answer strobe
  output logic rsp_denied, // answer was a refusal
  output logic [`FBP_DATA_W-1:0] rsp_data, // read data
  output logic busy, // erase in progress
  output logic viol_flag // sticky violation flag
);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [`FBP_DATA_W-1:0] mem [`FBP_WORDS]; // the flash array
  logic [`FBP_UNITS-1:0] attr_ro; // read-only attribute per unit
  logic [`FBP_UNITS-1:0] attr_xo; // execute-only attribute per unit
  ctrl_state_t state; // controller state
  logic [`FBP_BLK_W-1:0] erase_blk; // block being erased
  logic [`FBP_BLK_W-1:0] erase_cnt; // word within that block

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // refusal decision for one access against a unit's attributes
  function automatic logic refuse(input access_kind_t kind, input logic ro,
                                  input logic xo);
    logic r;
    r = 1'b0;
    case (kind)
      // R6: execute-only also blocks writes
      KIND_PROGRAM, KIND_ERASE: r = ro | xo;
      // R8: debugger reads refused like data
      KIND_DATA_READ, KIND_DEBUG_READ: r = xo;
      KIND_FETCH: r = 1'b0;
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  logic [`FBP_UNIT_W-1:0] req_unit; // protection unit of the request
  logic take; // request accepted this cycle
  logic deny; // accepted request is refused
  logic erase_go; // accepted erase starts
  logic erase_end; // last word of an erase

  // R4: unit index drops the block-pair bit
  assign req_unit = req_addr[`FBP_ADDR_W-1:`FBP_UNIT_LSB];
  assign take = req_valid && (state == ST_IDLE);
  // R5: refusal covers read-only and execute-only units
  assign deny = take && refuse(req_kind, attr_ro[req_unit], attr_xo[req_unit]);
  assign erase_go = take && !deny && (req_kind == KIND_ERASE);
  assign erase_end = (state == ST_ERASE) && (erase_cnt == `FBP_ERASE_LAST);

  // ----------------------------------------------------------------
  // protection attributes
  // ----------------------------------------------------------------
  // attributes only ever become more restrictive until reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      attr_ro <= `FBP_ATTR_RST;
      attr_xo <= `FBP_ATTR_RST;
    end else if (prot_set) begin
      // R4: one attribute per 2 KB unit
      attr_ro[prot_set_unit] <= attr_ro[prot_set_unit] | prot_set_ro;
      attr_xo[prot_set_unit] <= attr_xo[prot_set_unit] | prot_set_xo;
    end
  end

  // ----------------------------------------------------------------
  // erase sequencer
  // ----------------------------------------------------------------
  // walks one word per cycle through the chosen block
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      erase_blk <= '0;
      erase_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          // R2: erase picks one 1 KB block only
          if (erase_go) begin
            state <= ST_ERASE;
            busy <= 1'b1;
            erase_blk <= req_addr[`FBP_ADDR_W-1:`FBP_BLK_LSB];
            erase_cnt <= '0;
          end
        end
        ST_ERASE: begin
          erase_cnt <= erase_cnt + 8'h01;
          if (erase_end) begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // array writes
  // ----------------------------------------------------------------
  // contents are non-volatile, so the array takes no reset
  always_ff @(posedge clk) begin
    // R3: erase drives every word to ones
    if (state == ST_ERASE) begin
      mem[{erase_blk, erase_cnt}] <= `FBP_ERASED;
    end else if (take && !deny && (req_kind == KIND_PROGRAM)) begin
      // R1: programming can only clear bits
      mem[req_addr] <= mem[req_addr] & req_wdata;
    end
  end

  // ----------------------------------------------------------------
  // answers
  // ----------------------------------------------------------------
  // one answer per accepted request; erase answers at its end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp_denied <= 1'b0;
      rsp_data <= `FBP_DATA_RST;
    end else if (erase_end) begin
      rsp_valid <= 1'b1;
      rsp_denied <= 1'b0;
      rsp_data <= `FBP_DATA_RST;
    end else if (take) begin
      // R9: answer on the very next edge
      rsp_valid <= (req_kind != KIND_ERASE) || deny;
      rsp_denied <= deny;
      // R7: refused reads return zero, not contents
      if (!deny && (req_kind != KIND_PROGRAM) && (req_kind != KIND_ERASE)) begin
        rsp_data <= mem[req_addr];
      end else begin
        rsp_data <= `FBP_DATA_RST;
      end
    end else begin
      rsp_valid <= 1'b0;
      rsp_denied <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // violation flag
  // ----------------------------------------------------------------
  // a refusal in the clearing cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      viol_flag <= 1'b0;
    end else begin
      // R10: sticky, set wins over clear
      viol_flag <= (viol_flag & ~viol_clear) | deny;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic cur_ro; // attributes of the unit addressed now
  logic cur_xo;
  assign cur_ro = attr_ro[req_unit];
  assign cur_xo = attr_xo[req_unit];

  sequence erase_start_s;
    erase_go;
  endsequence
  sequence erase_run_s;
    busy [*8];
  endsequence

  read_latency_a: assert property ( // R9
    take && !deny && (req_kind inside {KIND_FETCH, KIND_DATA_READ, KIND_DEBUG_READ})
      |=> rsp_valid && !rsp_denied && (rsp_data == mem[$past(req_addr)]))
    else $error("permitted read not answered next cycle");

  ro_write_deny_a: assert property ( // R5
    take && cur_ro && (req_kind inside {KIND_PROGRAM, KIND_ERASE})
      |=> rsp_valid && rsp_denied && !busy)
    else $error("write to read-only unit not refused");

  xo_write_deny_a: assert property ( // R6
    take && cur_xo && (req_kind inside {KIND_PROGRAM, KIND_ERASE})
      |=> rsp_valid && rsp_denied && !busy)
    else $error("write to execute-only unit not refused");

  xo_data_deny_a: assert property ( // R7
    take && cur_xo && (req_kind == KIND_DATA_READ)
      |=> rsp_denied && (rsp_data == `FBP_DATA_RST))
    else $error("data read of execute-only unit not refused");

  xo_fetch_ok_a: assert property ( // R7
    take && (req_kind == KIND_FETCH) |=> rsp_valid && !rsp_denied)
    else $error("instruction fetch wrongly refused");

  xo_debug_deny_a: assert property ( // R8
    take && cur_xo && (req_kind == KIND_DEBUG_READ)
      |=> rsp_denied && (rsp_data == `FBP_DATA_RST))
    else $error("debugger read of execute-only unit not refused");

  viol_sticky_a: assert property ( // R10
    deny |=> viol_flag ##1 ($past(viol_clear) || viol_flag))
    else $error("violation flag not set or lost without a clear");

  erase_busy_a: assert property ( // R2
    erase_start_s |=> erase_run_s)
    else $error("erase did not hold busy");

  erase_done_a: assert property ( // R2
    erase_start_s |-> ##256 (busy && !rsp_valid) ##1 (rsp_valid && !rsp_denied && !busy))
    else $error("erase did not end after 256 words");

  erase_ones_a: assert property ( // R3
    state == ST_ERASE |=> mem[{$past(erase_blk), $past(erase_cnt)}] == `FBP_ERASED)
    else $error("erased word does not read as ones");

endmodule

`default_nettype wire

// >>> flash_block_protection_consts.svh
// constants for the flash block protection logic
`ifndef FLASH_BLOCK_PROTECTION_CONSTS_SVH
`define FLASH_BLOCK_PROTECTION_CONSTS_SVH

// array geometry: 256 KB as 32-bit words
`define FBP_ADDR_W 16
`define FBP_WORDS 65536
`define FBP_DATA_W 32
// 1 KB erase block = 256 words, 2 KB protection unit = 512 words
`define FBP_BLK_LSB 8
`define FBP_UNIT_LSB 9
`define FBP_UNIT_W 7
`define FBP_UNITS 128
`define FBP_BLK_W 8
// erase walks 256 words of a block
`define FBP_ERASE_LAST 8'hff
// erased value and reset values
`define FBP_ERASED 32'hffffffff
`define FBP_DATA_RST 32'h00000000
`define FBP_ATTR_RST 128'h0

`endif

// >>> flash_block_protection_pkg.sv
// types for the flash block protection logic
package flash_block_protection_pkg;

  // access kinds presented by core and debugger
  typedef enum logic [2:0] {
    KIND_FETCH = 3'b000,
    KIND_DATA_READ = 3'b001,
    KIND_DEBUG_READ = 3'b010,
    KIND_PROGRAM = 3'b011,
    KIND_ERASE = 3'b100
  } access_kind_t;

  // controller states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ERASE = 1'b1
  } ctrl_state_t;

endpackage

// >>> flash_requester.sv
// request model standing for the core buses and the debugger
`include "flash_block_protection_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module flash_requester
  import flash_block_protection_pkg::*;
(
  input wire logic clk,
  output logic req_valid,
  output var access_kind_t req_kind,
  output logic [`FBP_ADDR_W-1:0] req_addr,
  output logic [`FBP_DATA_W-1:0] req_wdata
);
  // quiet bus at time zero
  initial begin
    req_valid = 1'b0;
    req_kind = KIND_FETCH;
    req_addr = 16'h0000;
    req_wdata = 32'h00000000;
  end

  // one request, held until its taking edge has passed
  task automatic access(input access_kind_t k, input logic [15:0] a, input logic [31:0] d);
    req_valid = 1'b1;
    req_kind = k;
    req_addr = a;
    req_wdata = d;
    @(posedge clk);
    #1;
  endtask

  // release: address and data lines show the inverse of their last value
  task automatic idle();
    req_valid = 1'b0;
    req_addr = ~req_addr;
    req_wdata = ~req_wdata;
    @(posedge clk);
    #1;
  endtask
endmodule

`default_nettype wire

// >>> flash_block_protection_bench.sv
// self-checking bench for the flash block protection logic
`include "flash_block_protection_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module flash_block_protection_bench
  import flash_block_protection_pkg::*;
;
  typedef struct {logic dn; logic [31:0] d; int due;} note_t;
  logic clk, reset_n, prot_set, prot_set_ro, prot_set_xo, viol_clear;
  logic [6:0] prot_set_unit;
  wire logic req_valid;
  wire access_kind_t req_kind;
  wire logic [15:0] req_addr;
  wire logic [31:0] req_wdata;
  logic rsp_valid, rsp_denied, busy, viol_flag;
  logic [31:0] rsp_data, d, d2;
  logic [7:0] off;
  int n_fail = 0, samples_checked = 0, cyc = 0, seed = 30;
  note_t notes[$];
  note_t nt;

  flash_block_protection i_dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata), .prot_set(prot_set),
    .prot_set_unit(prot_set_unit), .prot_set_ro(prot_set_ro), .prot_set_xo(prot_set_xo),
    .viol_clear(viol_clear), .rsp_valid(rsp_valid), .rsp_denied(rsp_denied),
    .rsp_data(rsp_data), .busy(busy), .viol_flag(viol_flag));
  flash_requester i_core (.clk(clk), .req_valid(req_valid), .req_kind(req_kind),
    .req_addr(req_addr), .req_wdata(req_wdata));

  // clock and cycle count
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("counts: %0d checked, %0d failed", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one access with its expected answer, then wait out any erase
  task automatic op(input access_kind_t k, input logic [15:0] a, input logic [31:0] wd,
                    input logic dn, input logic [31:0] e, input int lat);
    notes.push_back('{dn, e, cyc + lat});
    i_core.access(k, a, wd);
    i_core.idle();
    for (int w = 0; w < 300 && busy !== 1'b0; w++) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic prot(input logic [6:0] u, input logic ro, input logic xo);
    prot_set = 1'b1;
    prot_set_unit = u;
    prot_set_ro = ro;
    prot_set_xo = xo;
    @(posedge clk);
    #1;
    prot_set = 1'b0;
  endtask

  // sticky flag seen, then cleared
  task automatic viol_test();
    check({31'h0, viol_flag}, 32'h1);
    viol_clear = 1'b1;
    @(posedge clk);
    #1;
    viol_clear = 1'b0;
    check({31'h0, viol_flag}, 32'h0);
  endtask

  // answer watcher: oldest note against each answer, sampled mid-cycle
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        nt = notes.pop_front();
        check(rsp_data, nt.d);
        check({31'h0, rsp_denied}, {31'h0, nt.dn});
        check(cyc, nt.due);
      end
    end
  end

  initial begin
    reset_n = 1'b0;
    {prot_set, prot_set_ro, prot_set_xo, viol_clear} = 4'h0;
    prot_set_unit = 7'h00;
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check({29'h0, busy, viol_flag, rsp_valid}, 32'h0);
    d = $random(seed);
    d2 = $random(seed);
    off = $random(seed);
    // erase the three blocks used below; the answer follows the last word
    op(KIND_ERASE, 16'h0200, 32'h0, 1'b0, 32'h0, 257);
    op(KIND_ERASE, 16'h0300, 32'h0, 1'b0, 32'h0, 257);
    op(KIND_ERASE, 16'h0400, 32'h0, 1'b0, 32'h0, 257);
    op(KIND_DATA_READ, {8'h03, off}, 32'h0, 1'b0, `FBP_ERASED, 1);
    op(KIND_PROGRAM, {8'h02, off}, d, 1'b0, 32'h0, 1);
    op(KIND_PROGRAM, {8'h04, off}, d2, 1'b0, 32'h0, 1);
    // erase the neighbour block: programmed word must survive
    op(KIND_ERASE, 16'h0300, 32'h0, 1'b0, 32'h0, 257);
    op(KIND_DATA_READ, {8'h02, off}, 32'h0, 1'b0, d, 1);
    $display("test erase done");
    // back-to-back reads, no wait states
    notes.push_back('{1'b0, d, cyc + 1});
    i_core.access(KIND_FETCH, {8'h02, off}, 32'h0);
    notes.push_back('{1'b0, d, cyc + 1});
    i_core.access(KIND_DEBUG_READ, {8'h02, off}, 32'h0);
    i_core.idle();
    $display("test back_to_back done");
    // read-only unit 1 (blocks 2 and 3)
    prot(7'h01, 1'b1, 1'b0);
    op(KIND_PROGRAM, {8'h02, off}, 32'h0, 1'b1, 32'h0, 1);
    op(KIND_ERASE, 16'h0300, 32'h0, 1'b1, 32'h0, 1);
    op(KIND_DATA_READ, {8'h02, off}, 32'h0, 1'b0, d, 1);
    viol_test();
    $display("test read_only done");
    // execute-only unit 2 (blocks 4 and 5)
    prot(7'h02, 1'b0, 1'b1);
    op(KIND_FETCH, {8'h04, off}, 32'h0, 1'b0, d2, 1);
    op(KIND_DATA_READ, {8'h04, off}, 32'h0, 1'b1, 32'h0, 1);
    op(KIND_DEBUG_READ, {8'h04, off}, 32'h0, 1'b1, 32'h0, 1);
    op(KIND_PROGRAM, {8'h04, off}, 32'h0, 1'b1, 32'h0, 1);
    op(KIND_ERASE, 16'h0500, 32'h0, 1'b1, 32'h0, 1);
    op(KIND_FETCH, {8'h04, off}, 32'h0, 1'b0, d2, 1);
    // undefined access kind on an unprotected unit is refused
    op(access_kind_t'(3'b101), {8'h06, off}, 32'h0, 1'b1, 32'h0, 1);
    viol_test();
    $display("test execute_only done");
    repeat (3) @(posedge clk);
    check(notes.size(), 32'h0);
    complete_run();
  end

  // watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule

`default_nettype wire
